//--- core/cfg_pin_defines.svh
// Constants for the configuration pin control block.
`ifndef CFG_PIN_DEFINES_SVH
`define CFG_PIN_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CORE_CLK_NS 10
`define MASTER_WAIT_NS 50000
`define MASTER_WAIT_CYC ((`MASTER_WAIT_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define CLEAR_CYC 64
`define CONFIG_CLOCK_HALF_CYC 3'h4
`define BUSY_NS 80
`define BUSY_CYC ((`BUSY_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

// ----------------------------------------------------------------
// Mode-select pin codes
// ----------------------------------------------------------------
`define MSEL_MASTER_SERIAL 3'h0
`define MSEL_MASTER_PAR_UP 3'h4
`define MSEL_MASTER_PAR_DN 3'h6
`define MSEL_SYNC_PERIPH 3'h3
`define MSEL_ASYNC_PERIPH 3'h5
`define MSEL_EXPRESS 3'h2
`define MSEL_SLAVE_SERIAL 3'h7

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define IO_CELLS 8
`define ADDR_W 18
`define ADDR_UP_START 18'h00000
`define ADDR_DN_START 18'h3ffff
`define STATUS_FILL 7'h7f
`define SYNC_W 19

`endif

//--- core/cfg_pin_pkg.sv
// Types and mode decoding for the configuration pin control block.
`include "cfg_pin_defines.svh"

package cfg_pin_pkg;

   typedef enum logic [2:0] {
      MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL, MODE_MASTER_PAR_UP,
      MODE_MASTER_PAR_DN, MODE_SYNC_PERIPH, MODE_ASYNC_PERIPH,
      MODE_EXPRESS
   } load_mode_e;

   typedef enum logic [2:0] {
      ST_CLEAR, ST_WAIT, ST_MDELAY, ST_LOAD, ST_DONE_DLY,
      ST_STARTUP, ST_USER, ST_ERROR
   } cfg_state_e;

   // Unlisted pin codes fall back to slave serial, the safe default.
   function automatic load_mode_e mode_decode(input logic [2:0] sel);
      case (sel)
         `MSEL_MASTER_SERIAL: mode_decode = MODE_MASTER_SERIAL;
         `MSEL_MASTER_PAR_UP: mode_decode = MODE_MASTER_PAR_UP;
         `MSEL_MASTER_PAR_DN: mode_decode = MODE_MASTER_PAR_DN;
         `MSEL_SYNC_PERIPH: mode_decode = MODE_SYNC_PERIPH;
         `MSEL_ASYNC_PERIPH: mode_decode = MODE_ASYNC_PERIPH;
         `MSEL_EXPRESS: mode_decode = MODE_EXPRESS;
         default: mode_decode = MODE_SLAVE_SERIAL;
      endcase
   endfunction

   function automatic logic is_master(input load_mode_e m);
      is_master = (m == MODE_MASTER_SERIAL) || (m == MODE_MASTER_PAR_UP) ||
                  (m == MODE_MASTER_PAR_DN);
   endfunction

   function automatic logic drives_config_clock(input load_mode_e m);
      drives_config_clock = is_master(m) || (m == MODE_ASYNC_PERIPH);
   endfunction

endpackage

//--- core/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps

module pin_sync #(
   parameter int W = 1
) (
   input wire logic core_clk, // Core clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic [W-1:0] d, // Asynchronous pin levels.
   output logic [W-1:0] q // Synchronised levels.
);

   logic [W-1:0] meta_q;

   // Idle level is high, which matches the active-low pins it carries.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_q <= '1;
         q <= '1;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

//--- core/config_pin_control.sv
// Configuration pin control: clear, wait, load, done and startup.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cfg_pin_defines.svh"

module config_pin_control #(
   parameter int MASTER_WAIT_CYC = `MASTER_WAIT_CYC
) (
   input wire logic core_clk, // Core clock, 100 MHz.
   input wire logic rst, // Power-up reset, active high.
   input wire logic clear_req_n, // Clear request pin.
   input wire logic init_n_in, // Init status pin level.
   output logic init_n_out, // Init drive value, always low.
   output logic init_n_oe, // Init pulled low when high.
   input wire logic done_in, // Completion pin level.
   output logic done_out, // Completion drive value.
   output logic done_oe, // Completion pin driven low.
   output logic done_pullup_en, // Completion pin pull-up.
   input wire logic done_pullup_opt, // Option: keep pull-up.
   input wire logic done_wait_en, // Option: hold on low done.
   input wire logic done_clk_sel, // Option: 1 times by clock.
   input wire logic [1:0] done_delay, // Option: done delay ticks.
   input wire logic config_clock_in, // Config clock pin level.
   output logic config_clock_out, // Config clock drive value.
   output logic config_clock_oe, // Config clock driven.
   input wire logic readback_sel, // Readback from config clock.
   output logic readback_clk, // Readback clock level.
   input wire logic [2:0] load_mode_sel, // Mode-select pins.
   input wire logic cs0_n, // Chip select, active low.
   input wire logic cs1, // Chip select, active high.
   input wire logic ws_n, // Write strobe, active low.
   input wire logic rs_n, // Read strobe, active low.
   input wire logic [7:0] data_in, // Data pins, bit 0 serial.
   output logic [7:0] data_out, // Status byte for reads.
   output logic data_oe, // Data pins driven.
   output logic rdy_busy, // High when ready.
   output logic rdy_busy_oe, // Ready/busy driven.
   output logic [`ADDR_W-1:0] prom_address, // PROM address.
   output logic prom_address_oe, // PROM address driven.
   output logic addr_strobe, // Address strobe.
   input wire logic cfg_error, // Data error from checker.
   input wire logic [15:0] cfg_length, // Bytes in bitstream.
   output logic [7:0] cfg_byte, // Assembled byte.
   output logic cfg_byte_valid, // One-cycle byte pulse.
   input wire logic [`IO_CELLS-1:0] io_used, // Cells used.
   output logic [`IO_CELLS-1:0] io_pullup_en, // Cell pull-ups.
   output logic [`IO_CELLS-1:0] io_oe_allow, // Cell drive allowed.
   output logic special_pins_user, // Special pins are user I/O.
   output logic gsr_release, // Global init released.
   input wire logic bscan_keep, // Boundary scan kept.
   output logic tdo_tristate // Test output three-stated.
);
   import cfg_pin_pkg::*;

   // ----------------------------------------------------------------
   // Synchronised pins
   // ----------------------------------------------------------------
   logic [`SYNC_W-1:0] pins_s;
   logic clr_n_s, init_s, done_s, config_clock_s, cs0_n_s, cs1_s, ws_n_s, rs_n_s;
   logic [2:0] msel_s;
   logic [7:0] data_s;

   pin_sync #(.W(`SYNC_W)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({clear_req_n, init_n_in, done_in, config_clock_in, cs0_n, cs1,
          ws_n, rs_n, load_mode_sel, data_in}),
      .q(pins_s)
   );

   assign {clr_n_s, init_s, done_s, config_clock_s, cs0_n_s, cs1_s, ws_n_s,
           rs_n_s, msel_s, data_s} = pins_s;

   // ----------------------------------------------------------------
   // State and datapath registers
   // ----------------------------------------------------------------
   cfg_state_e state_q;
   load_mode_e mode_q;
   logic [15:0] cnt_q, byte_cnt_q;
   logic [2:0] div_q, bit_q;
   logic [3:0] busy_q;
   logic [7:0] shift_q;
   logic config_clock_q, config_clock_prev_q, ws_prev_q, astep_q;
   logic own_rise, own_fall, ext_rise, clk_edge, sel, wr_fall, take;
   logic [7:0] new_byte;

   // Own clock edges come from the divider; far-side edges are sampled.
   assign own_rise = (div_q == `CONFIG_CLOCK_HALF_CYC - 3'h1) && !config_clock_q;
   assign own_fall = (div_q == `CONFIG_CLOCK_HALF_CYC - 3'h1) && config_clock_q;
   assign ext_rise = config_clock_s && !config_clock_prev_q;
   assign clk_edge = drives_config_clock(mode_q) ? own_rise : ext_rise;
   assign sel = !cs0_n_s && cs1_s;
   assign wr_fall = sel && !ws_n_s && ws_prev_q;

   // Byte assembly per mode; serial modes gather eight bits, msb first.
   always_comb begin
      take = 1'b0;
      new_byte = data_s;
      if (state_q == ST_LOAD) begin
         case (mode_q)
            MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL: begin
               take = clk_edge && (bit_q == 3'h7);
               new_byte = {shift_q[6:0], data_s[0]};
            end
            MODE_ASYNC_PERIPH: take = wr_fall;
            MODE_EXPRESS: take = clk_edge && cs1_s;
            default: take = clk_edge;
         endcase
      end
   end

   // Main sequence; the clear request wins from every state.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_CLEAR;
         cnt_q <= 16'h0000;
         mode_q <= MODE_SLAVE_SERIAL;
      end else begin
         if (!clr_n_s) begin
            state_q <= ST_CLEAR;
            cnt_q <= 16'h0000;
         end else begin
            case (state_q)
               ST_CLEAR: begin
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == 16'(`CLEAR_CYC - 1)) begin
                     state_q <= ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  cnt_q <= 16'h0000;
                  if (init_s) begin
                     mode_q <= mode_decode(msel_s);
                     state_q <= is_master(mode_decode(msel_s)) ?
                                ST_MDELAY : ST_LOAD;
                  end
               end
               ST_MDELAY: begin
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == 16'(MASTER_WAIT_CYC - 1)) begin
                     state_q <= ST_LOAD;
                  end
               end
               ST_LOAD: begin
                  cnt_q <= 16'h0000;
                  if (cfg_error) begin
                     state_q <= ST_ERROR;
                  end else if (take && byte_cnt_q == cfg_length - 16'h1) begin
                     state_q <= ST_DONE_DLY;
                  end
               end
               ST_DONE_DLY: begin
                  if (cnt_q >= {14'h0000, done_delay}) begin
                     state_q <= ST_STARTUP;
                  end else if (!done_clk_sel || clk_edge) begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               ST_STARTUP: begin
                  if (!(done_wait_en && !done_s)) begin
                     state_q <= ST_USER;
                  end
               end
               ST_USER: state_q <= ST_USER;
               ST_ERROR: state_q <= ST_ERROR;
               default: state_q <= ST_CLEAR;
            endcase
         end
      end
   end

   // Byte shift, count and output pulse.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_q <= 8'h00;
         bit_q <= 3'h0;
         byte_cnt_q <= 16'h0000;
         cfg_byte <= 8'h00;
         cfg_byte_valid <= 1'b0;
      end else begin
         cfg_byte_valid <= take;
         if (state_q != ST_LOAD) begin
            bit_q <= 3'h0;
            byte_cnt_q <= 16'h0000;
         end else if (clk_edge || take) begin
            shift_q <= {shift_q[6:0], data_s[0]};
            bit_q <= bit_q + 3'h1;
            if (take) begin
               byte_cnt_q <= byte_cnt_q + 16'h0001;
            end
         end
         if (take) begin
            cfg_byte <= new_byte;
         end
      end
   end

   // Clock divider and edge history; the divider runs in every mode and state.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q <= 3'h0;
         config_clock_q <= 1'b0;
         config_clock_prev_q <= 1'b1;
         ws_prev_q <= 1'b1;
      end else begin
         config_clock_prev_q <= config_clock_s;
         ws_prev_q <= ws_n_s;
         if (div_q == `CONFIG_CLOCK_HALF_CYC - 3'h1) begin
            div_q <= 3'h0;
            config_clock_q <= !config_clock_q;
         end else begin
            div_q <= div_q + 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_q <= 4'h0;
      end else if (take && (mode_q == MODE_ASYNC_PERIPH ||
                            mode_q == MODE_SYNC_PERIPH)) begin
         busy_q <= 4'(`BUSY_CYC);
      end else if (busy_q != 4'h0) begin
         busy_q <= busy_q - 4'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prom_address <= `ADDR_UP_START;
         addr_strobe <= 1'b0;
         astep_q <= 1'b0;
      end else begin
         astep_q <= take && (mode_q == MODE_MASTER_PAR_UP ||
                             mode_q == MODE_MASTER_PAR_DN);
         if (state_q == ST_WAIT) begin
            prom_address <= (mode_decode(msel_s) == MODE_MASTER_PAR_DN) ?
                            `ADDR_DN_START : `ADDR_UP_START;
         end else if (astep_q) begin
            prom_address <= (mode_q == MODE_MASTER_PAR_DN) ?
                            prom_address - 18'h1 : prom_address + 18'h1;
         end
         if (take && (mode_q == MODE_MASTER_PAR_UP ||
                      mode_q == MODE_MASTER_PAR_DN)) begin
            addr_strobe <= 1'b1;
         end else if (own_fall) begin
            addr_strobe <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else begin
         data_out <= {busy_q == 4'h0, `STATUS_FILL};
         // The write strobe overrides a read if both are low.
         data_oe <= state_q == ST_LOAD && mode_q == MODE_ASYNC_PERIPH &&
                    sel && !rs_n_s && ws_n_s;
      end
   end

   // Pin ownership after configuration, registered to keep pins clean.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         io_pullup_en <= '1;
         io_oe_allow <= '0;
         tdo_tristate <= 1'b0;
         readback_clk <= 1'b0;
         done_pullup_en <= 1'b1;
      end else begin
         io_pullup_en <= (state_q == ST_USER) ? ~io_used : '1;
         io_oe_allow <= (state_q == ST_USER) ? io_used : '0;
         tdo_tristate <= (state_q == ST_USER) && !bscan_keep;
         readback_clk <= (state_q == ST_USER) && readback_sel && config_clock_s;
         done_pullup_en <= done_pullup_opt;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // Init low in clear
   assign init_n_oe = (state_q == ST_CLEAR) || (state_q == ST_ERROR);
   assign init_n_out = 1'b0;
   assign done_oe = (state_q != ST_STARTUP) && (state_q != ST_USER);
   assign done_out = 1'b0;
   assign config_clock_oe = drives_config_clock(mode_q) && (state_q == ST_MDELAY ||
                            state_q == ST_LOAD || state_q == ST_DONE_DLY);
   assign config_clock_out = config_clock_q;
   assign rdy_busy_oe = state_q == ST_LOAD && (mode_q == MODE_ASYNC_PERIPH ||
                        mode_q == MODE_SYNC_PERIPH);
   assign rdy_busy = busy_q == 4'h0;
   assign prom_address_oe = state_q == ST_LOAD &&
      (mode_q == MODE_MASTER_PAR_UP || mode_q == MODE_MASTER_PAR_DN);
   assign special_pins_user = state_q == ST_USER;
   assign gsr_release = state_q == ST_USER;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Cycles since the clear request was last seen low; it saturates so a
   // long stay in user mode never wraps back into the checked window.
   logic [6:0] clr_hi_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clr_hi_q <= 7'h00;
      end else if (!clr_n_s) begin
         clr_hi_q <= 7'h00;
      end else if (clr_hi_q != 7'h7f) begin
         clr_hi_q <= clr_hi_q + 7'h01;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_CLEAR_PASS: assert property (
      clr_n_s && clr_hi_q == 7'(`CLEAR_CYC - 1)
      |=> state_q == ST_WAIT && !init_n_oe)
      else $error("clear pass length wrong");
   AST_CLEAR_FORCE: assert property (
      !clr_n_s |=> state_q == ST_CLEAR && init_n_oe)
      else $error("clear request ignored");
   AST_WAIT_HOLD: assert property (
      state_q == ST_WAIT && !init_s && clr_n_s |=> state_q == ST_WAIT)
      else $error("left wait with init low");
   AST_SLAVE_DEFAULT: assert property (
      state_q == ST_WAIT && init_s && clr_n_s && msel_s == 3'h7
      |=> mode_q == MODE_SLAVE_SERIAL)
      else $error("all-high mode not slave serial");
   AST_MODE_HOLD: assert property (
      state_q != ST_WAIT |=> $stable(mode_q))
      else $error("mode changed outside wait");
   AST_CONFIG_CLOCK_DIR: assert property (
      state_q == ST_LOAD |-> config_clock_oe == drives_config_clock(mode_q))
      else $error("config clock direction wrong");
   AST_ADDR_STROBE: assert property (
      state_q == ST_LOAD && $past(state_q) == ST_LOAD &&
      prom_address != $past(prom_address) |-> $past(addr_strobe, 1))
      else $error("address moved without strobe");
   AST_MASTER_WAIT: assert property (
      $past(state_q) == ST_MDELAY && state_q == ST_LOAD && $past(clr_n_s)
      |-> $past(cnt_q) == 16'(MASTER_WAIT_CYC - 1))
      else $error("master wait too short");
   AST_ERR_INIT: assert property (
      state_q == ST_LOAD && cfg_error && clr_n_s |=> init_n_oe [*2])
      else $error("error not reported on init");
   AST_STARTUP_HOLD: assert property (
      state_q == ST_STARTUP && done_wait_en && !done_s |=> !gsr_release)
      else $error("startup passed low done");
   AST_RDY_PULLUP: assert property (
      init_n_oe || state_q == ST_WAIT |-> !rdy_busy_oe)
      else $error("ready driven before init high");

   COV_USER: cover property (state_q == ST_DONE_DLY ##[1:20] gsr_release);
   COV_PAR_BYTE: cover property (addr_strobe ##1 astep_q);
   COV_ASYNC_WR: cover property (wr_fall && state_q == ST_LOAD);

endmodule

//--- bench/serial_host_model.sv
// Serial host model that clocks bytes into the device, msb first.
`timescale 1ns/1ps

module serial_host_model (
   output logic sclk, // Link clock, still between frames.
   output logic sdata // Serial data line.
);
   // Clock idles low; data idles high until the first frame.
   initial begin
      sclk = 1'b0;
      sdata = 1'b1;
   end
   // Host clocks data; high time may stretch.
   task automatic send_byte(input logic [7:0] b, input realtime hi_ns);
      // Start off the core clock edge so the pins never race its sampling.
      #1;
      for (int i = 7; i >= 0; i--) begin
         sdata = b[i];
         #62.5 sclk = 1'b1;
         #(hi_ns) sclk = 1'b0;
      end
      // Released line shows the inverse, so stale data never looks valid.
      #62.5 sdata = ~sdata;
   endtask
endmodule

//--- bench/config_pin_control_bench.sv
// Self-checking bench for the configuration pin control block.
`timescale 1ns/1ps
`include "cfg_pin_defines.svh"

module config_pin_control_bench;
   import cfg_pin_pkg::*;
   localparam int MWAIT = 20;
   logic core_clk, init_n_in, init_n_out, init_n_oe, done_in, done_out;
   logic rst = 1'b1, clear_req_n = 1'b1, init_hold_n = 1'b1;
   logic done_hold_n = 1'b0, done_pullup_opt = 1'b1, done_wait_en = 1'b1;
   logic done_clk_sel = 1'b0, readback_sel = 1'b1, bscan_keep = 1'b0;
   logic cs0_n = 1'b1, cs1 = 1'b0, ws_n = 1'b1, rs_n = 1'b1;
   logic cfg_error = 1'b0, use_ser = 1'b1;
   logic [1:0] done_delay = 2'h2;
   logic [2:0] load_mode_sel = 3'h7;
   logic [7:0] par_data = 8'h00, io_used = 8'h5a;
   logic [15:0] cfg_length = 16'h0002;
   logic done_oe, done_pullup_en, config_clock_in, config_clock_out;
   logic config_clock_oe, readback_clk, data_oe, rdy_busy, rdy_busy_oe;
   logic prom_address_oe, addr_strobe, cfg_byte_valid, special_pins_user;
   logic gsr_release, tdo_tristate, sclk, sdata;
   logic [7:0] data_in, data_out, cfg_byte, io_pullup_en, io_oe_allow;
   logic [`ADDR_W-1:0] prom_address;
   logic [7:0] got[$];
   int failures = 0;
   int checks = 0;

   // Init, done and config clock resolved from both drivers; open-drain lines take the bench hold level when free.
   assign init_n_in = init_n_oe ? 1'b0 : init_hold_n;
   assign done_in = done_oe ? 1'b0 : done_hold_n;
   assign config_clock_in = config_clock_oe ? config_clock_out : sclk;
   assign data_in = use_ser ? {7'h7f, sdata} : par_data;

   config_pin_control #(.MASTER_WAIT_CYC(MWAIT)) dut (.*);
   serial_host_model host (.sclk(sclk), .sdata(sdata));

   // Collect every assembled byte the device announces.
   always @(posedge core_clk) begin
      if (cfg_byte_valid === 1'b1) got.push_back(cfg_byte);
   end
   // Free-running core clock, 100 MHz.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Watchdog: the run needs far fewer than 50k cycles.
   initial begin
      #500000;
      failures++;
      report_and_stop();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Clear with a new mode; bounded wait keeps a stuck pass from hanging.
   task automatic do_clear(input logic [2:0] m);
      int n;
      load_mode_sel <= m;
      clear_req_n <= 1'b0;
      tick(4);
      check(init_n_oe, 1'b1);
      check(rdy_busy_oe, 1'b0);
      clear_req_n <= 1'b1;
      for (n = 0; n < 200 && init_n_oe !== 1'b0; n++) tick(1);
      check(n >= 64 && n <= 72, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check(init_n_oe, 1'b1);
      check(init_n_out, 1'b0);
      check(io_pullup_en, 8'hff);
      check(done_pullup_en, 1'b1);
      check(special_pins_user, 1'b0);
   endtask
   // Done rise is timed by link clock rises, so it waits for a spare frame.
   task automatic t_slave();
      int n;
      init_hold_n <= 1'b0;
      done_pullup_opt <= 1'b0;
      done_clk_sel <= 1'b1;
      do_clear(3'h7);
      host.send_byte(8'hc3, 62.5);
      tick(10);
      check(got.size(), 0);
      init_hold_n <= 1'b1;
      tick(10);
      check(config_clock_oe, 1'b0);
      host.send_byte(8'h96, 62.5);
      host.send_byte(8'h3c, 400);
      tick(10);
      check({got[0], got[1]}, 16'h963c);
      check(done_oe, 1'b1);
      host.send_byte(8'h00, 62.5);
      for (n = 0; n < 50 && done_oe !== 1'b0; n++) tick(1);
      check(done_oe, 1'b0);
      check(done_out, 1'b0);
      tick(20);
      check(gsr_release, 1'b0);
      done_hold_n <= 1'b1;
      tick(5);
      check(gsr_release, 1'b1);
      check(special_pins_user, 1'b1);
      check(io_pullup_en, 8'(~io_used));
      check(io_oe_allow, io_used);
      check(tdo_tristate, 1'b1);
      check(done_pullup_en, 1'b0);
      fork
         host.send_byte(8'hff, 200);
         begin
            for (n = 0; n < 100 && readback_clk !== 1'b1; n++) tick(1);
            check(readback_clk, 1'b1);
         end
      join
      tick(1);
      bscan_keep <= 1'b1;
      tick(2);
      check(tdo_tristate, 1'b0);
   endtask
   task automatic t_async();
      logic clk_was;
      use_ser <= 1'b0;
      got.delete();
      do_clear(3'h5);
      tick(10);
      load_mode_sel <= 3'h7;
      tick(5);
      check(config_clock_oe, 1'b1);
      // The own clock flips every half period of four core cycles.
      clk_was = config_clock_out;
      tick(4);
      check(config_clock_out, !clk_was);
      par_data <= 8'ha5;
      cs0_n <= 1'b0;
      cs1 <= 1'b1;
      ws_n <= 1'b0;
      tick(3);
      ws_n <= 1'b1;
      tick(2);
      check({rdy_busy_oe, rdy_busy}, 2'b10);
      rs_n <= 1'b0;
      tick(4);
      check({data_oe, data_out}, 9'h17f);
      tick(10);
      check({data_oe, data_out}, 9'h1ff);
      rs_n <= 1'b1;
      check(got[0], 8'ha5);
      cfg_error <= 1'b1;
      tick(3);
      check(init_n_oe, 1'b1);
      cfg_error <= 1'b0;
      cs0_n <= 1'b1;
   endtask
   // Every pin code, the spare one included; only drivers own the clock.
   task automatic t_modes();
      logic exp;
      cfg_length <= 16'hffff;
      for (int c = 0; c < 8; c++) begin
         exp = (c == 0) || (c == 4) || (c == 5) || (c == 6);
         do_clear(c[2:0]);
         tick(40);
         check(config_clock_oe, exp);
      end
   endtask
   task automatic t_master();
      int n;
      logic seen_rise, prev_s;
      logic [`ADDR_W-1:0] last_a;
      do_clear(3'h4);
      for (n = 0; n < 200 && prom_address_oe !== 1'b1; n++) tick(1);
      check(n >= MWAIT, 1'b1);
      check(prom_address_oe, 1'b1);
      check(prom_address, 18'h00000);
      seen_rise = 1'b0;
      prev_s = addr_strobe;
      last_a = prom_address;
      for (n = 0; n < 40; n++) begin
         tick(1);
         if (addr_strobe === 1'b1 && prev_s === 1'b0) seen_rise = 1'b1;
         prev_s = addr_strobe;
         if (prom_address !== last_a) begin
            check(seen_rise, 1'b1);
            check(prom_address, last_a + 1'b1);
            seen_rise = 1'b0;
            last_a = prom_address;
         end
      end
      check(last_a != 18'h00000, 1'b1);
   endtask

   // Main sequence: reset held for six cycles, then each scenario.
   initial begin
      tick(5);
      t_reset();
      tick(1);
      rst <= 1'b0;
      t_slave();
      t_async();
      t_modes();
      t_master();
      report_and_stop();
   end
endmodule
